// ==== bench/cctb_chk.sv ====
// checker of pin, interrupt and capture timing at the unit's ports
`timescale 1ns/10ps
module cctb_chk (
   input wire logic       clk,
   input wire logic       reset,
   input wire logic [7:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic       bus_wr,
   input wire logic       bus_rd,
   input wire logic [1:0] event_pin_in,
   input wire logic [1:0] event_pin_out,
   input wire logic [1:0] event_pin_oe,
   input wire logic       irq
);
   logic [3:0] m1_ff;
   logic [3:0] m2_ff;
   logic [1:0] mask_ff;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // shadow the modes and mask from the write strobe, same edge as the unit
   always_ff @(posedge clk) begin
      if (reset) begin
         m1_ff   <= 4'h0;
         m2_ff   <= 4'h0;
         mask_ff <= 2'h0;
      end else if (bus_wr) begin
         if (bus_addr == 8'h00) m1_ff <= bus_wdata[3:0];
         if (bus_addr == 8'h01) m2_ff <= bus_wdata[3:0];
         if (bus_addr == 8'h0A) mask_ff <= bus_wdata[1:0];
      end
   end
   // own decode, so a slip in the shared one is not copied
   function automatic logic drv(input logic [3:0] m);
      drv = (m == 4'h2) || (m == 4'h8) || (m == 4'h9);
   endfunction
   property p_oe_mode;
      event_pin_oe == {drv(m2_ff), drv(m1_ff)};
   endproperty
   a_oe_mode: assert property (p_oe_mode)
      else $error("pin enable does not follow mode");
   property p_off_low;
      (m2_ff == 4'h0) |=> !event_pin_out[1];
   endproperty
   a_off_low: assert property (p_off_low)
      else $error("output latch not low while off");
   property p_quiet;
      (m2_ff inside {4'hA, 4'hB}) |=> $stable(event_pin_out[1]);
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("latch moved in a quiet mode");
   property p_set;
      (m2_ff == 4'h8) |=> !$fell(event_pin_out[1]);
   endproperty
   a_set: assert property (p_set)
      else $error("latch fell in set mode");
   property p_clr;
      (m2_ff == 4'h9) |=> !$rose(event_pin_out[1]);
   endproperty
   a_clr: assert property (p_clr)
      else $error("latch rose in clear mode");
   property p_cap;
      (m1_ff == 4'h5 && mask_ff[0] && $rose(event_pin_in[0])) |=> irq;
   endproperty
   a_cap: assert property (p_cap)
      else $error("capture edge raised no interrupt");
   property p_hold;
      (irq && !bus_rd && !bus_wr) |=> irq;
   endproperty
   a_hold: assert property (p_hold)
      else $error("interrupt dropped without a read");
   property p_mask0;
      (mask_ff == 2'h0) |-> !irq;
   endproperty
   a_mask0: assert property (p_mask0)
      else $error("interrupt with empty mask");
   c_cap16: cover property (m1_ff == 4'h7 && $rose(irq));
   c_set: cover property (m2_ff == 4'h8 && $rose(event_pin_out[1]));
   c_tog: cover property (m2_ff == 4'h2 && $rose(event_pin_out[1]));
endmodule

bind cctb_unit cctb_chk i_chk (.clk(clk), .reset(reset),
   .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
   .bus_rd(bus_rd), .event_pin_in(event_pin_in),
   .event_pin_out(event_pin_out), .event_pin_oe(event_pin_oe), .irq(irq));

// ==== bench/cctb_pin_model.sv ====
// event pins and external timebase clock outside the unit
`timescale 1ns/10ps
module cctb_pin_model (
   input  wire logic [1:0] pin_out,
   input  wire logic [1:0] pin_oe,
   input  wire logic       clk,
   output logic      [1:0] pin_in,
   output logic            ext_clk
);
   logic [1:0] lvl;
   // the pin reads back what the unit drives, else the outside level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & lvl);
   initial begin
      lvl     = 2'h0;
      ext_clk = 1'b0;
   end
   // clock pulses; the line rests low between them
   task automatic ext_pulse(input int n);
      repeat (n) begin
         @(posedge clk) ext_clk <= 1'b1;
         @(posedge clk) ext_clk <= 1'b0;
      end
   endtask
   task automatic drive(input int ch, input logic v);
      @(posedge clk) lvl[ch] <= v;
   endtask
endmodule

// ==== bench/tb_capture_compare_timebase_unit.sv ====
// self-checking bench of the two-channel capture/compare unit
`timescale 1ns/10ps
`include "cctb_map.svh"
`define TB_CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tb_capture_compare_timebase_unit;
   logic        clk, reset, bus_wr, bus_rd, sleep_mode, irq, ext_clk_in;
   logic [7:0]  bus_addr, bus_wdata, bus_rdata, d;
   logic [1:0]  pin_in, pin_out, pin_oe, stat, mask;
   logic [31:0] rnd = 32'h0000_4c2b;
   logic [3:0]  capm [4] = '{4'h4, 4'h5, 4'h6, 4'h7};
   logic [3:0]  cmpm [5] = '{4'h8, 4'h9, 4'h2, 4'hA, 4'hB};
   int          n_fail = 0, n_compared = 0, tbm, pre, lat, n;
   int          cap_q[$];
   cctb_unit i_dut (.clk(clk), .reset(reset), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata), .sleep_mode(sleep_mode),
      .ext_clk_in(ext_clk_in), .event_pin_in(pin_in),
      .event_pin_out(pin_out), .event_pin_oe(pin_oe), .irq(irq));
   cctb_pin_model i_pin (.pin_out(pin_out), .pin_oe(pin_oe), .clk(clk),
      .pin_in(pin_in), .ext_clk(ext_clk_in));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] w);
      @(posedge clk);
      bus_wr    <= 1'b1;
      bus_addr  <= a;
      bus_wdata <= w;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      bus_rd   <= 1'b1;
      bus_addr <= a;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1 d = bus_rdata;
   endtask
   task automatic chk16(input logic [7:0] a, input int e);
      rd(a);
      `TB_CHK(d, e[7:0])
      rd(a + 8'h01);
      `TB_CHK(d, e[15:8])
   endtask
   // status read clears it, so the model clears too
   task automatic chk_stat();
      @(negedge clk);
      `TB_CHK(irq, |(stat & mask))
      `TB_CHK({pin_oe[0], pin_out[0]}, 2'h0)
      rd(`CCTB_A_STATUS);
      `TB_CHK(d, {6'h00, stat})
      stat = 2'h0;
   endtask
   // capture model for one pin edge; prescaler survives 01xx changes
   task automatic cap_edge(input logic [3:0] m, input logic rise);
      int last;
      last = (m == 4'h6) ? 3 : 15;
      if ((m == 4'h4 && !rise) || (m == 4'h5 && rise) ||
          (m[1] && rise && pre == last)) begin
         cap_q.push_back(tbm);
         stat[0] = 1'b1;
      end
      if (m[1] && rise) pre = (pre == last) ? 0 : pre + 1;
   endtask
   task automatic final_report();
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      final_report();
   end
   initial begin
      {reset, bus_wr, bus_rd, sleep_mode} = 4'h8;
      bus_addr  = 8'h00;
      bus_wdata = 8'h00;
      stat      = 2'h0;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      for (int a = 0; a < 12; a++) begin
         rd(a[7:0]);
         `TB_CHK(d, `CCTB_RST_BYTE)
      end
      wr(`CCTB_A_CTL1, 8'hFF);
      rd(`CCTB_A_CTL1);
      `TB_CHK(d, 8'h3F)
      for (int a = 2; a < 6; a++) begin
         rnd = lfsr(rnd);
         wr(a[7:0], rnd[7:0]);
         rd(a[7:0]);
         `TB_CHK(d, rnd[7:0])
      end
      $display("test registers done");
      // external source keeps counting while asleep
      @(posedge clk) sleep_mode <= 1'b1;
      wr(`CCTB_A_TBCTL, 8'h03);
      wr(`CCTB_A_TB_LO, 8'hFE);
      wr(`CCTB_A_TB_HI, 8'h12);
      rnd = lfsr(rnd);
      n   = rnd[2:0] + 3;
      i_pin.ext_pulse(n);
      tbm = 16'h12FE + n;
      chk16(`CCTB_A_TB_LO, tbm);
      $display("test external timebase done");
      mask = 2'h1;
      wr(`CCTB_A_MASK, 8'h01);
      foreach (capm[i]) begin
         if (capm[i] != 4'h7) begin
            wr(`CCTB_A_CTL1, 8'h00);
            pre = 0;
         end
         wr(`CCTB_A_CTL1, {4'h0, capm[i]});
         chk_stat();
         repeat (21) begin
            rnd = lfsr(rnd);
            n   = rnd[1:0] + 1;
            i_pin.ext_pulse(n);
            tbm = (tbm + n) % 65536;
            i_pin.drive(0, 1'b1);
            cap_edge(capm[i], 1'b1);
            repeat (2) @(posedge clk);
            i_pin.drive(0, 1'b0);
            cap_edge(capm[i], 1'b0);
            repeat (3) @(posedge clk);
            chk16(`CCTB_A_VAL1_LO, cap_q[$]);
            chk_stat();
         end
      end
      $display("test capture done");
      mask = 2'h0;
      wr(`CCTB_A_MASK, 8'h00);
      wr(`CCTB_A_CTL1, 8'h00);
      chk_stat();
      foreach (cmpm[i]) begin
         if (!(cmpm[i] inside {4'h9, 4'hA})) begin
            wr(`CCTB_A_CTL2, 8'h00);
            lat = 0;
         end
         rnd = lfsr(rnd);
         n   = rnd[2:0] + 3;
         wr(`CCTB_A_TB_LO, 8'h00);
         wr(`CCTB_A_TB_HI, 8'h00);
         wr(`CCTB_A_VAL2_LO, n[7:0]);
         wr(`CCTB_A_VAL2_HI, 8'h00);
         wr(`CCTB_A_CTL2, {4'h0, cmpm[i]});
         i_pin.ext_pulse(n);
         if (cmpm[i] == 4'h2) lat = 1 - lat;
         if (cmpm[i][3:1] == 3'h4) lat = (cmpm[i] == 4'h8);
         stat[1] = 1'b1;
         repeat (2) @(posedge clk);
         @(negedge clk);
         `TB_CHK(pin_out[1], lat[0])
         `TB_CHK(pin_oe[1], cmpm[i] inside {4'h2, 4'h8, 4'h9})
         i_pin.ext_pulse(1);
         tbm = (cmpm[i] == 4'hB) ? 0 : n + 1;
         chk16(`CCTB_A_TB_LO, tbm);
         chk_stat();
      end
      $display("test compare done");
      // instruction clock holds during sleep and resumes from there
      wr(`CCTB_A_TBCTL, 8'h01);
      wr(`CCTB_A_TB_LO, 8'hFF);
      wr(`CCTB_A_TB_HI, 8'h00);
      repeat (8) @(posedge clk);
      @(posedge clk) sleep_mode <= 1'b0;
      repeat (40) @(posedge clk);
      sleep_mode <= 1'b1;
      repeat (8) @(posedge clk);
      chk16(`CCTB_A_TB_LO, 16'h0109);
      $display("test sleep done");
      final_report();
   end
endmodule

// ==== rtl/cctb_channel.sv ====
// one capture/compare channel: value pair, prescaler, pin latch
`timescale 1ns/10ps
`include "cctb_map.svh"
module cctb_channel (
   input  wire logic               clk,
   input  wire logic               reset,
   input  wire cctb_pkg::cctb_mode_t mode,
   input  wire logic [15:0]        timebase,
   input  wire logic               pin_in,
   input  wire logic               wr_low,
   input  wire logic               wr_high,
   input  wire logic [7:0]         wdata,
   output cctb_pkg::cctb_chan_t    chan
);

   logic [15:0] value_ff;
   logic        pin_q_ff;
   logic [3:0]  presc_ff;
   logic        match_q_ff;
   logic        latch_ff;
   logic        rise;
   logic        fall;
   logic        cap_evt;
   logic        match;
   logic        cmp_evt;

   // pin edges, the pin is taken as synchronous
   always_ff @(posedge clk) begin
      if (reset) begin
         pin_q_ff <= 1'b0;
      end else begin
         pin_q_ff <= pin_in;
      end
   end
   assign rise = pin_in & ~pin_q_ff;
   assign fall = ~pin_in & pin_q_ff;

   // prescaler survives a change between capture settings
   always_ff @(posedge clk) begin
      if (reset || !cctb_pkg::cctb_is_capture(mode)) begin
         presc_ff <= `CCTB_PS_ZERO;
      end else if (rise && mode[1]) begin
         if (presc_ff >= ((mode == `CCTB_M_CAP_4) ? `CCTB_PS4_LAST
                                                  : `CCTB_PS16_LAST)) begin
            presc_ff <= `CCTB_PS_ZERO;
         end else begin
            presc_ff <= presc_ff + `CCTB_PS_ONE;
         end
      end
   end

   // qualifying capture event per mode
   always_comb begin
      cap_evt = 1'b0;
      unique case (mode)
         `CCTB_M_CAP_FALL: cap_evt = fall;
         `CCTB_M_CAP_RISE: cap_evt = rise;
         `CCTB_M_CAP_4:    cap_evt = rise && (presc_ff == `CCTB_PS4_LAST);
         `CCTB_M_CAP_16:   cap_evt = rise && (presc_ff == `CCTB_PS16_LAST);
         default:          cap_evt = 1'b0;
      endcase
   end

   // equality is level; only its first cycle counts as a match event
   assign match   = cctb_pkg::cctb_is_compare(mode) &&
                    (value_ff == timebase);
   assign cmp_evt = match & ~match_q_ff;

   always_ff @(posedge clk) begin
      if (reset) begin
         match_q_ff <= 1'b0;
      end else begin
         match_q_ff <= match;
      end
   end

   // value pair: a capture wins over a firmware byte write
   always_ff @(posedge clk) begin
      if (reset) begin
         value_ff <= `CCTB_RST_WORD;
      end else if (cap_evt) begin
         value_ff <= timebase;
      end else begin
         if (wr_low) begin
            value_ff[7:0] <= wdata;
         end
         if (wr_high) begin
            value_ff[15:8] <= wdata;
         end
      end
   end

   // compare output latch, forced low while the unit is off
   always_ff @(posedge clk) begin
      if (reset || mode == `CCTB_M_OFF) begin
         latch_ff <= 1'b0;
      end else if (cmp_evt) begin
         unique case (mode)
            `CCTB_M_TOGGLE: latch_ff <= ~latch_ff;
            `CCTB_M_SET:    latch_ff <= 1'b1;
            `CCTB_M_CLEAR:  latch_ff <= 1'b0;
            default:        latch_ff <= latch_ff;
         endcase
      end
   end

   assign chan.value       = value_ff;
   assign chan.event_pulse = cap_evt | cmp_evt;
   assign chan.pin_out     = latch_ff;
   assign chan.pin_oe      = cctb_pkg::cctb_drives_pin(mode);
   assign chan.special     = match && (mode == `CCTB_M_SPECIAL);

endmodule

// ==== rtl/cctb_unit.sv ====
// two-channel capture/compare unit with its 16-bit timebase
//
// Functional notes
// - capture uses the 16-bit timebase, from instruction or external clock
// - on instruction clock the timebase holds in sleep, then resumes
// - on external clock capture keeps working during sleep
// - timebase is 16 bits, read as low and high byte registers
// - compare mode checks value pair against timebase for equality
// - a match toggles, sets or clears the pin, resets timebase or flags
// - every compare mode sets the event flag on a match
// - compare codes 0010, 1000, 1001, 1010, 1011; 0000 turns unit off
// - capture codes 0100 fall, 0101 rise, 0110 fourth, 0111 sixteenth rise
// - capture loads timebase into value pair, sets flag, overwrites unread
// - prescaler zeroed when off, not capturing or reset; not on swaps between capture modes
`timescale 1ns/10ps
`include "cctb_map.svh"
module cctb_unit (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic [7:0] bus_addr,
   input  wire logic [7:0] bus_wdata,
   input  wire logic       bus_wr,
   input  wire logic       bus_rd,
   output logic      [7:0] bus_rdata,
   input  wire logic       sleep_mode,
   input  wire logic       ext_clk_in,
   input  wire logic [1:0] event_pin_in,
   output logic      [1:0] event_pin_out,
   output logic      [1:0] event_pin_oe,
   output logic            irq
);

   cctb_pkg::cctb_req_t  req;
   cctb_pkg::cctb_chan_t chan1;
   cctb_pkg::cctb_chan_t chan2;

   logic [7:0]  ctl1_ff;
   logic [7:0]  ctl2_ff;
   logic [7:0]  tbctl_ff;
   logic [15:0] tb_ff;
   logic [15:0] nxt_tb;
   logic [1:0]  div_ff;
   logic        ext_q_ff;
   logic [1:0]  status_ff;
   logic [1:0]  nxt_status;
   logic [1:0]  mask_ff;
   logic [7:0]  rdata_ff;
   logic [7:0]  nxt_rdata;
   logic        inst_tick;
   logic        ext_rise;
   logic        tb_tick;
   logic        tb_on;
   logic        tb_ext;
   logic        special_any;
   logic [1:0]  events;

   // bundle the register port
   assign req.wr    = bus_wr;
   assign req.rd    = bus_rd;
   assign req.addr  = bus_addr;
   assign req.wdata = bus_wdata;

   // write decode, one strobe per register
   function automatic logic hit_wr(input cctb_pkg::cctb_req_t r,
                                   input logic [7:0] a);
      hit_wr = r.wr && (r.addr == a);
   endfunction

   assign tb_on  = tbctl_ff[`CCTB_TBC_ON];
   assign tb_ext = tbctl_ff[`CCTB_TBC_EXT];

   // control registers; bits 7:6 are not implemented
   // a mode change takes effect in one write; clearing the register
   // first is firmware's job, so no interlock is built here
   always_ff @(posedge clk) begin
      if (reset) begin
         ctl1_ff <= `CCTB_RST_BYTE;
      end else if (hit_wr(req, `CCTB_A_CTL1)) begin
         ctl1_ff <= req.wdata & `CCTB_CTL_WMASK;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ctl2_ff <= `CCTB_RST_BYTE;
      end else if (hit_wr(req, `CCTB_A_CTL2)) begin
         ctl2_ff <= req.wdata & `CCTB_CTL_WMASK;
      end
   end

   // timebase control: run enable and clock source
   always_ff @(posedge clk) begin
      if (reset) begin
         tbctl_ff <= `CCTB_RST_BYTE;
      end else if (hit_wr(req, `CCTB_A_TBCTL)) begin
         tbctl_ff <= req.wdata & `CCTB_TBC_WMASK;
      end
   end

   // instruction clock is a quarter of clk, made as an enable pulse
   always_ff @(posedge clk) begin
      if (reset) begin
         div_ff <= `CCTB_DIV_ZERO;
      end else begin
         div_ff <= div_ff + `CCTB_DIV_ONE;
      end
   end
   assign inst_tick = (div_ff == `CCTB_DIV_LAST);

   // external clock is sampled; one edge per count
   always_ff @(posedge clk) begin
      if (reset) begin
         ext_q_ff <= 1'b0;
      end else begin
         ext_q_ff <= ext_clk_in;
      end
   end
   assign ext_rise = ext_clk_in & ~ext_q_ff;

   // the instruction clock stops in sleep, the external one does not
   assign tb_tick = tb_on &&
                    (tb_ext ? ext_rise
                            : (inst_tick && !sleep_mode));

   // a special event clears the count at the next timebase edge,
   // so the match value acts as a period; moving the value away
   // before that edge cancels the clear
   assign special_any = chan1.special | chan2.special;

   // next timebase value; firmware byte writes win over counting
   always_comb begin
      nxt_tb = tb_ff;
      if (tb_tick) begin
         if (special_any) begin
            nxt_tb = `CCTB_RST_WORD;
         end else begin
            nxt_tb = tb_ff + `CCTB_TB_ONE;
         end
      end
      if (hit_wr(req, `CCTB_A_TB_LO)) begin
         nxt_tb[7:0] = req.wdata;
      end
      if (hit_wr(req, `CCTB_A_TB_HI)) begin
         nxt_tb[15:8] = req.wdata;
      end
   end

   // timebase register; it holds, not clears, while stopped
   always_ff @(posedge clk) begin
      if (reset) begin
         tb_ff <= `CCTB_RST_WORD;
      end else begin
         tb_ff <= nxt_tb;
      end
   end

   // both channels share the one timebase
   cctb_channel u_chan1 (
      .clk      (clk),
      .reset    (reset),
      .mode     (ctl1_ff[`CCTB_CTL_MODE]),
      .timebase (tb_ff),
      .pin_in   (event_pin_in[0]),
      .wr_low   (hit_wr(req, `CCTB_A_VAL1_LO)),
      .wr_high  (hit_wr(req, `CCTB_A_VAL1_HI)),
      .wdata    (req.wdata),
      .chan     (chan1)
   );

   cctb_channel u_chan2 (
      .clk      (clk),
      .reset    (reset),
      .mode     (ctl2_ff[`CCTB_CTL_MODE]),
      .timebase (tb_ff),
      .pin_in   (event_pin_in[1]),
      .wr_low   (hit_wr(req, `CCTB_A_VAL2_LO)),
      .wr_high  (hit_wr(req, `CCTB_A_VAL2_HI)),
      .wdata    (req.wdata),
      .chan     (chan2)
   );

   // pins: the enable follows the mode, so flag-only modes let go
   assign event_pin_out = {chan2.pin_out, chan1.pin_out};
   assign event_pin_oe  = {chan2.pin_oe, chan1.pin_oe};

   // event flags from capture and compare
   assign events = {chan2.event_pulse, chan1.event_pulse};

   // sticky status; a read clears it but a new event in that cycle
   // survives, so no capture is lost to a racing read
   always_comb begin
      nxt_status = status_ff;
      if (req.rd && req.addr == `CCTB_A_STATUS) begin
         nxt_status = `CCTB_RST_IRQ;
      end
      nxt_status = nxt_status | events;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         status_ff <= `CCTB_RST_IRQ;
      end else begin
         status_ff <= nxt_status;
      end
   end

   // interrupt mask, same layout as the status register
   always_ff @(posedge clk) begin
      if (reset) begin
         mask_ff <= `CCTB_RST_IRQ;
      end else if (hit_wr(req, `CCTB_A_MASK)) begin
         mask_ff <= req.wdata[1:0];
      end
   end

   // level interrupt while any unmasked flag stands
   assign irq = |(status_ff & mask_ff);

   // read mux; unmapped offsets answer zero
   always_comb begin
      nxt_rdata = `CCTB_RST_BYTE;
      unique case (req.addr)
         `CCTB_A_CTL1:    nxt_rdata = ctl1_ff;
         `CCTB_A_CTL2:    nxt_rdata = ctl2_ff;
         `CCTB_A_VAL1_LO: nxt_rdata = chan1.value[7:0];
         `CCTB_A_VAL1_HI: nxt_rdata = chan1.value[15:8];
         `CCTB_A_VAL2_LO: nxt_rdata = chan2.value[7:0];
         `CCTB_A_VAL2_HI: nxt_rdata = chan2.value[15:8];
         `CCTB_A_TB_LO:   nxt_rdata = tb_ff[7:0];
         `CCTB_A_TB_HI:   nxt_rdata = tb_ff[15:8];
         `CCTB_A_TBCTL:   nxt_rdata = tbctl_ff;
         `CCTB_A_STATUS:  nxt_rdata = {6'h00, status_ff};
         `CCTB_A_MASK:    nxt_rdata = {6'h00, mask_ff};
         default:         nxt_rdata = `CCTB_RST_BYTE;
      endcase
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_ff <= `CCTB_RST_BYTE;
      end else if (req.rd) begin
         rdata_ff <= nxt_rdata;
      end else begin
         rdata_ff <= `CCTB_RST_BYTE;
      end
   end
   assign bus_rdata = rdata_ff;

endmodule

// ==== shared/cctb_map.svh ====
// register offsets, field positions, mode codes and counts of the unit
`ifndef CCTB_MAP_SVH
`define CCTB_MAP_SVH

// register byte offsets on the plain register port
`define CCTB_A_CTL1      8'h00
`define CCTB_A_CTL2      8'h01
`define CCTB_A_VAL1_LO   8'h02
`define CCTB_A_VAL1_HI   8'h03
`define CCTB_A_VAL2_LO   8'h04
`define CCTB_A_VAL2_HI   8'h05
`define CCTB_A_TB_LO     8'h06
`define CCTB_A_TB_HI     8'h07
`define CCTB_A_TBCTL     8'h08
`define CCTB_A_STATUS    8'h09
`define CCTB_A_MASK      8'h0A

// field layout of the control registers
`define CCTB_CTL_MODE    3:0
`define CCTB_CTL_WMASK   8'h3F
`define CCTB_TBC_ON      0
`define CCTB_TBC_EXT     1
`define CCTB_TBC_WMASK   8'h03

// reset values
`define CCTB_RST_BYTE    8'h00
`define CCTB_RST_WORD    16'h0000
`define CCTB_RST_IRQ     2'h0

// mode select codes
`define CCTB_M_OFF       4'h0
`define CCTB_M_TOGGLE    4'h2
`define CCTB_M_CAP_FALL  4'h4
`define CCTB_M_CAP_RISE  4'h5
`define CCTB_M_CAP_4     4'h6
`define CCTB_M_CAP_16    4'h7
`define CCTB_M_SET       4'h8
`define CCTB_M_CLEAR     4'h9
`define CCTB_M_FLAG      4'hA
`define CCTB_M_SPECIAL   4'hB

// counts
`define CCTB_PS4_LAST    4'h3
`define CCTB_PS16_LAST   4'hF
`define CCTB_PS_ZERO     4'h0
`define CCTB_PS_ONE      4'h1
`define CCTB_DIV_LAST    2'h3
`define CCTB_DIV_ZERO    2'h0
`define CCTB_DIV_ONE     2'h1
`define CCTB_TB_ONE      16'h0001

`endif

// ==== shared/cctb_pkg.sv ====
// types and mode decoding shared by the capture/compare unit
`include "cctb_map.svh"
package cctb_pkg;

   typedef logic [3:0] cctb_mode_t;

   // one register port request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cctb_req_t;

   // what one channel reports back to the top
   typedef struct packed {
      logic [15:0] value;
      logic        event_pulse;
      logic        pin_out;
      logic        pin_oe;
      logic        special;
   } cctb_chan_t;

   // capture modes are 01xx
   function automatic logic cctb_is_capture(input cctb_mode_t m);
      cctb_is_capture = (m[3:2] == 2'b01);
   endfunction

   // compare modes are 0010 and 10xx
   function automatic logic cctb_is_compare(input cctb_mode_t m);
      cctb_is_compare = (m == `CCTB_M_TOGGLE) || (m[3:2] == 2'b10);
   endfunction

   // only toggle, set and clear take the pin
   function automatic logic cctb_drives_pin(input cctb_mode_t m);
      cctb_drives_pin = (m == `CCTB_M_TOGGLE) || (m == `CCTB_M_SET) ||
                        (m == `CCTB_M_CLEAR);
   endfunction

endpackage
